// ---- common/sispd_pkg.sv ----
// Package with opcodes, field positions, reset values and carrier types of the serial decoder.
package sispd_pkg;
  localparam logic [7:0] SISPD_OP_PROG = 8'hAC;
  localparam logic [7:0] SISPD_SUB_ENABLE = 8'h53;
  localparam logic [7:0] SISPD_SUB_ERASE = 8'h80;
  localparam logic [7:0] SISPD_SUB_LOCK_WR = 8'hE0;
  localparam logic [7:0] SISPD_SUB_FUSE_LO_WR = 8'hA0;
  localparam logic [7:0] SISPD_SUB_FUSE_HI_WR = 8'hA8;
  localparam logic [7:0] SISPD_SUB_FUSE_EX_WR = 8'hA4;
  localparam logic [7:0] SISPD_OP_POLL = 8'hF0;
  localparam logic [7:0] SISPD_OP_EXT_ADDR = 8'h4D;
  localparam logic [7:0] SISPD_OP_LOAD_HI = 8'h48;
  localparam logic [7:0] SISPD_OP_LOAD_LO = 8'h40;
  localparam logic [7:0] SISPD_OP_EE_LOAD = 8'hC1;
  localparam logic [7:0] SISPD_OP_EE_PAGE = 8'hC2;
  localparam logic [7:0] SISPD_OP_EE_WRITE = 8'hC0;
  localparam logic [7:0] SISPD_OP_EE_READ = 8'hA0;
  localparam logic [7:0] SISPD_OP_RD_HI = 8'h28;
  localparam logic [7:0] SISPD_OP_RD_LO = 8'h20;
  localparam logic [7:0] SISPD_OP_WR_PAGE = 8'h4C;
  localparam logic [7:0] SISPD_OP_CFG_A = 8'h50;
  localparam logic [7:0] SISPD_OP_CFG_B = 8'h58;
  localparam logic [7:0] SISPD_SUB_CFG_ALT = 8'h08;
  localparam logic [7:0] SISPD_OP_SIG = 8'h30;
  localparam logic [7:0] SISPD_OP_CAL = 8'h38;
  // Unprogrammed fuse and lock bits read as one.
  localparam logic [7:0] SISPD_CFG_RESET = 8'hFF;
  localparam logic [7:0] SISPD_ZERO = 8'h00;
  localparam int SISPD_EE_PAGE_BITS = 2;
  localparam int SISPD_BUSY_BIT = 0;

  typedef enum logic [3:0] {
    SISPD_M_NONE = 4'h0, SISPD_M_ERASE = 4'h1, SISPD_M_FLASH_PAGE = 4'h2,
    SISPD_M_EE_BYTE = 4'h3, SISPD_M_EE_PAGE = 4'h4, SISPD_M_LOCK = 4'h5,
    SISPD_M_FUSE_LO = 4'h6, SISPD_M_FUSE_HI = 4'h7, SISPD_M_FUSE_EX = 4'h8
  } sispd_mem_op_t;

  // One received instruction, bytes 1 to 4 in arrival order.
  typedef struct packed {
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
  } sispd_instr_t;

  // Request to the memory and configuration side.
  typedef struct packed {
    logic valid;
    sispd_mem_op_t op;
    logic [23:0] addr;
    logic [7:0] data;
  } sispd_mem_req_t;

  typedef struct packed {
    logic [7:0] lock;
    logic [7:0] fuse_lo;
    logic [7:0] fuse_hi;
    logic [7:0] fuse_ex;
  } sispd_cfg_t;
endpackage

// ---- src/sispd_link.sv ----
// Serial link shifter clocked by the programmer's serial clock.
`timescale 1ns/1ps
module sispd_link
  import sispd_pkg::*;
(
  input wire logic sck,
  input wire logic rst,
  input wire logic mosi,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic miso_oe,
  output logic byte_tgl,
  output logic [1:0] byte_idx,
  output logic [7:0] rx_byte
);
  typedef struct packed {
    logic [7:0] sh;
    logic [2:0] bit_cnt;
    logic [1:0] idx;
    logic tgl;
    logic [7:0] rx;
  } sispd_rx_st_t;

  sispd_rx_st_t r_q, r_d;
  logic [7:0] tx_q;

  // Bits are taken on the rising serial clock edge.
  always_comb begin
    r_d = r_q;
    r_d.sh = {r_q.sh[6:0], mosi};
    r_d.bit_cnt = r_q.bit_cnt + 3'h1;
    if (r_q.bit_cnt == 3'h7) begin
      r_d.rx = {r_q.sh[6:0], mosi};
      r_d.tgl = ~r_q.tgl;
      r_d.idx = r_q.idx + 2'h1;
    end
  end

  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // Output bits change on the falling edge; the next byte is loaded before its first bit.
  always_ff @(negedge sck or posedge rst) begin
    if (rst) begin
      tx_q <= 8'h00;
    end else if (r_q.bit_cnt == 3'h0) begin
      tx_q <= {tx_byte[6:0], 1'b0};
    end else begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  logic miso_q;
  always_ff @(negedge sck or posedge rst) begin
    if (rst) begin
      miso_q <= 1'b0;
    end else begin
      miso_q <= (r_q.bit_cnt == 3'h0) ? tx_byte[7] : tx_q[7];
    end
  end

  assign miso = miso_q;
  // The pin is released whenever the link is held in reset.
  assign miso_oe = ~rst;
  assign byte_tgl = r_q.tgl;
  assign byte_idx = r_q.idx;
  assign rx_byte = r_q.rx;
endmodule // sispd_link

// ---- src/sispd_decoder.sv ----
// Serial in-system programming instruction decoder with configuration store.
`timescale 1ns/1ps
module sispd_decoder
  import sispd_pkg::*;
#(
  parameter logic [7:0] SIG_BYTE0 = 8'h11, // Arbitrary identity value.
  parameter logic [7:0] SIG_BYTE1 = 8'h22, // Arbitrary identity value.
  parameter logic [7:0] SIG_BYTE2 = 8'h33, // Arbitrary identity value.
  parameter logic [7:0] CAL_BYTE = 8'h80
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic mosi,
  input wire logic reset_pin_n,
  output logic miso,
  output logic miso_oe,
  output sispd_mem_req_t mem_req,
  input wire logic mem_busy,
  input wire logic mem_rd_valid,
  input wire logic [7:0] mem_rd_data,
  output logic [15:0] page_wr_data,
  output logic [7:0] page_wr_addr,
  output logic page_wr_hi_en,
  output logic page_wr_lo_en,
  output logic [7:0] ee_buf_data,
  output logic [1:0] ee_buf_addr,
  output logic ee_buf_en,
  output sispd_cfg_t cfg,
  output logic prog_enabled,
  output logic pending_operation_flag
);
  localparam logic [1:0] BYTE_FOUR = 2'h3;
  localparam logic [1:0] BYTE_ONE = 2'h1;

  logic link_rst;
  logic byte_tgl;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;

  // The serial side is held in reset while the device reset pin is high.
  assign link_rst = rst | reset_pin_n;

  sispd_link u_link (
    .sck(sck),
    .rst(link_rst),
    .mosi(mosi),
    .tx_byte(tx_byte),
    .miso(miso),
    .miso_oe(miso_oe),
    .byte_tgl(byte_tgl),
    .byte_idx(),
    .rx_byte(rx_byte)
  );

  typedef struct packed {
    logic [2:0] tgl_sync;
    logic [1:0] rst_sync;
    logic [1:0] byte_n;
    sispd_instr_t ins;
    logic enabled;
    logic [7:0] ext_addr;
    logic [7:0] reply;
    sispd_mem_req_t req;
    logic [15:0] pw_data;
    logic [7:0] pw_addr;
    logic pw_hi;
    logic pw_lo;
    logic [7:0] eb_data;
    logic [1:0] eb_addr;
    logic eb_en;
    sispd_cfg_t cfg;
    logic [7:0] rd_hold;
  } sispd_st_t;

  sispd_st_t s_q, s_d;

  function automatic logic is_op(input logic [7:0] b, input logic [7:0] op);
    is_op = (b == op);
  endfunction

  // Byte-four reply chosen from the first two bytes and the current state.
  function automatic logic [7:0] cfg_pick(input logic [7:0] b1, input logic [7:0] b2,
                                          input sispd_cfg_t c);
    logic [7:0] v;
    v = SISPD_ZERO;
    if (is_op(b1, SISPD_OP_CFG_A) && is_op(b2, SISPD_ZERO)) v = c.fuse_lo;
    if (is_op(b1, SISPD_OP_CFG_B) && is_op(b2, SISPD_SUB_CFG_ALT)) v = c.fuse_hi;
    if (is_op(b1, SISPD_OP_CFG_A) && is_op(b2, SISPD_SUB_CFG_ALT)) v = c.fuse_ex;
    if (is_op(b1, SISPD_OP_CFG_B) && is_op(b2, SISPD_ZERO)) v = c.lock;
    cfg_pick = v;
  endfunction

  logic byte_evt;
  logic [7:0] b1, b2, b3, b4;
  logic busy;

  assign byte_evt = s_q.tgl_sync[2] ^ s_q.tgl_sync[1];
  assign busy = mem_busy | s_q.req.valid;

  always_comb begin
    s_d = s_q;
    s_d.tgl_sync = {s_q.tgl_sync[1:0], byte_tgl};
    s_d.rst_sync = {s_q.rst_sync[0], reset_pin_n};
    s_d.req.valid = 1'b0;
    s_d.pw_hi = 1'b0;
    s_d.pw_lo = 1'b0;
    s_d.eb_en = 1'b0;
    if (mem_rd_valid) begin
      s_d.rd_hold = mem_rd_data;
    end
    b1 = s_q.ins.b1;
    b2 = s_q.ins.b2;
    b3 = s_q.ins.b3;
    b4 = rx_byte;
    if (s_q.rst_sync[1]) begin
      s_d.enabled = 1'b0;
      s_d.byte_n = 2'h0;
    end else if (byte_evt) begin
      s_d.byte_n = s_q.byte_n + 2'h1;
      case (s_q.byte_n)
        2'h0: begin
          s_d.ins.b1 = rx_byte;
        end
        2'h1: begin
          s_d.ins.b2 = rx_byte;
          s_d.reply = rx_byte;
          if (is_op(b1, SISPD_OP_RD_HI) || is_op(b1, SISPD_OP_RD_LO) ||
              is_op(b1, SISPD_OP_EE_READ)) begin
            s_d.req.valid = 1'b0;
          end
        end
        2'h2: begin
          s_d.ins.b3 = rx_byte;
          s_d.reply = cfg_pick(b1, b2, s_q.cfg);
          if (is_op(b1, SISPD_OP_POLL)) begin
            s_d.reply = {7'h00, busy};
          end
          if (is_op(b1, SISPD_OP_SIG)) begin
            case (rx_byte[1:0])
              2'h0: s_d.reply = SIG_BYTE0;
              2'h1: s_d.reply = SIG_BYTE1;
              default: s_d.reply = SIG_BYTE2;
            endcase
          end
          if (is_op(b1, SISPD_OP_CAL)) begin
            s_d.reply = CAL_BYTE;
          end
          if (is_op(b1, SISPD_OP_RD_HI) || is_op(b1, SISPD_OP_RD_LO) ||
              is_op(b1, SISPD_OP_EE_READ)) begin
            s_d.reply = s_q.rd_hold;
          end
        end
        default: begin
          if (!s_q.enabled) begin
            if (is_op(b1, SISPD_OP_PROG) && is_op(b2, SISPD_SUB_ENABLE)) begin
              s_d.enabled = 1'b1;
            end
          end else begin
            s_d.req.addr = {s_q.ext_addr, b2, b3};
            s_d.req.data = b4;
            s_d.req.op = SISPD_M_NONE;
            case (b1)
              SISPD_OP_PROG: begin
                case (b2)
                  SISPD_SUB_ERASE: s_d.req.op = SISPD_M_ERASE;
                  SISPD_SUB_LOCK_WR: s_d.req.op = SISPD_M_LOCK;
                  SISPD_SUB_FUSE_LO_WR: s_d.req.op = SISPD_M_FUSE_LO;
                  SISPD_SUB_FUSE_HI_WR: s_d.req.op = SISPD_M_FUSE_HI;
                  SISPD_SUB_FUSE_EX_WR: s_d.req.op = SISPD_M_FUSE_EX;
                  default: s_d.req.op = SISPD_M_NONE;
                endcase
                // Zero bits mean programmed; values are stored as written.
                if (is_op(b2, SISPD_SUB_ERASE)) begin
                  s_d.cfg.lock = SISPD_CFG_RESET;
                end
                if (is_op(b2, SISPD_SUB_LOCK_WR)) s_d.cfg.lock = b4;
                if (is_op(b2, SISPD_SUB_FUSE_LO_WR)) s_d.cfg.fuse_lo = b4;
                if (is_op(b2, SISPD_SUB_FUSE_HI_WR)) s_d.cfg.fuse_hi = b4;
                if (is_op(b2, SISPD_SUB_FUSE_EX_WR)) s_d.cfg.fuse_ex = b4;
              end
              SISPD_OP_EXT_ADDR: s_d.ext_addr = b3;
              SISPD_OP_LOAD_HI: begin
                s_d.pw_addr = b3;
                s_d.pw_data[15:8] = b4;
                s_d.pw_hi = 1'b1;
              end
              SISPD_OP_LOAD_LO: begin
                s_d.pw_addr = b3;
                s_d.pw_data[7:0] = b4;
                s_d.pw_lo = 1'b1;
              end
              SISPD_OP_EE_LOAD: begin
                s_d.eb_addr = b3[SISPD_EE_PAGE_BITS-1:0];
                s_d.eb_data = b4;
                s_d.eb_en = 1'b1;
              end
              SISPD_OP_EE_PAGE: begin
                s_d.req.op = SISPD_M_EE_PAGE;
                s_d.req.addr = {8'h00, b2, b3[7:2], 2'h0};
              end
              SISPD_OP_WR_PAGE: s_d.req.op = SISPD_M_FLASH_PAGE;
              SISPD_OP_EE_WRITE: begin
                // EEPROM addresses never carry the program-memory extended byte.
                s_d.req.op = SISPD_M_EE_BYTE;
                s_d.req.addr = {8'h00, b2, b3};
              end
              default: s_d.req.op = SISPD_M_NONE;
            endcase
            s_d.req.valid = (s_d.req.op != SISPD_M_NONE);
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.cfg <= {SISPD_CFG_RESET, SISPD_CFG_RESET, SISPD_CFG_RESET, SISPD_CFG_RESET};
    end else begin
      s_q <= s_d;
    end
  end

  // Reply byte crosses as a multi-cycle stable word: it settles long before byte four starts.
  assign tx_byte = s_q.reply;
  assign mem_req = s_q.req;
  assign page_wr_data = s_q.pw_data;
  assign page_wr_addr = s_q.pw_addr;
  assign page_wr_hi_en = s_q.pw_hi;
  assign page_wr_lo_en = s_q.pw_lo;
  assign ee_buf_data = s_q.eb_data;
  assign ee_buf_addr = s_q.eb_addr;
  assign ee_buf_en = s_q.eb_en;
  assign cfg = s_q.cfg;
  assign prog_enabled = s_q.enabled;
  assign pending_operation_flag = busy;
endmodule // sispd_decoder

// ---- bench/sispd_decoder_props.sv ----
// Port-level assertions for the serial programming decoder.
`timescale 1ns/1ps
module sispd_decoder_props
  import sispd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_pin_n,
  input wire logic mem_busy,
  input wire sispd_mem_req_t mem_req,
  input wire logic page_wr_hi_en,
  input wire logic page_wr_lo_en,
  input wire logic ee_buf_en,
  input wire sispd_cfg_t cfg,
  input wire logic prog_enabled,
  input wire logic miso_oe,
  input wire logic pending_operation_flag
);
  logic [7:0] req_data_q;
  logic act;
  assign act = mem_req.valid | page_wr_lo_en | page_wr_hi_en | ee_buf_en;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_data_q <= 8'h00;
    end else if (mem_req.valid) begin
      req_data_q <= mem_req.data;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_req_one_cycle: assert property (mem_req.valid |=> !mem_req.valid)
    else $error("request pulse too long");
  a_one_action: assert property ($onehot0({mem_req.valid, page_wr_lo_en,
    page_wr_hi_en, ee_buf_en})) else $error("two actions at once");
  a_idle_when_off: assert property (!prog_enabled |-> !act)
    else $error("action while programming is off");
  a_busy_shown: assert property (mem_busy |-> ##[0:2] pending_operation_flag)
    else $error("pending flag missing");
  a_pin_leaves_mode: assert property (reset_pin_n [*6] |-> !prog_enabled)
    else $error("mode kept with reset pin high");
  a_lock_written: assert property (mem_req.valid && mem_req.op == SISPD_M_LOCK
    |=> ##[0:1] cfg.lock == req_data_q) else $error("lock byte not stored");
  a_erase_lock: assert property (mem_req.valid && mem_req.op == SISPD_M_ERASE
    |=> ##[0:1] cfg.lock == SISPD_CFG_RESET) else $error("lock not cleared by erase");
  a_cfg_caused: assert property ($changed(cfg) |-> mem_req.valid ||
    $past(mem_req.valid) || $past(mem_req.valid, 2)) else $error("config changed alone");
  a_oe_in_reset: assert property (reset_pin_n |-> !miso_oe)
    else $error("serial output driven while reset pin high");
endmodule // sispd_decoder_props

bind sispd_decoder sispd_decoder_props chk_u (
  .clk(clk), .rst(rst), .reset_pin_n(reset_pin_n), .mem_busy(mem_busy),
  .mem_req(mem_req), .page_wr_hi_en(page_wr_hi_en), .page_wr_lo_en(page_wr_lo_en),
  .ee_buf_en(ee_buf_en), .cfg(cfg), .prog_enabled(prog_enabled),
  .pending_operation_flag(pending_operation_flag), .miso_oe(miso_oe)
);

// ---- bench/sispd_prog_model.sv ----
// Behavioural serial programmer that drives the link and collects returned bytes.
`timescale 1ns/1ps
module sispd_prog_model (
  output logic sck,
  output logic mosi,
  input wire logic miso,
  output logic [7:0] got,
  output logic got_tgl
);
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    got = 8'h00;
    got_tgl = 1'b0;
  end
  // Always sends all four bytes, MSB first; sck stands low between frames.
  task automatic xfer(input logic [31:0] ins, input bit k3, input bit k4);
    logic [7:0] rx;
    for (int i = 31; i >= 0; i--) begin
      mosi = ins[i];
      #15 sck = 1'b1;
      rx = {rx[6:0], miso};
      #15 sck = 1'b0;
      if ((i == 8 && k3) || (i == 0 && k4)) begin
        got = rx;
        got_tgl = ~got_tgl;
      end
    end
    mosi = ~mosi;
  endtask
endmodule // sispd_prog_model

// ---- bench/sispd_decoder_tb.sv ----
// Self-checking testbench for the serial programming decoder.
`timescale 1ns/1ps
module sispd_decoder_tb;
  import sispd_pkg::*;
  localparam logic [23:0] SIGS = 24'h96C35A; // Arbitrary identity values.
  localparam logic [7:0] CAL = 8'h7E;
  logic clk, rst, reset_pin_n, mem_busy, mem_rd_valid, sck, mosi, miso, miso_oe;
  logic got_tgl, prog_enabled, pending_operation_flag;
  logic got_seen = 1'b0;
  logic page_wr_hi_en, page_wr_lo_en, ee_buf_en;
  logic [7:0] mem_rd_data, got, page_wr_addr, ee_buf_data, ext, a, d, w;
  logic [15:0] page_wr_data;
  logic [1:0] ee_buf_addr;
  sispd_mem_req_t mem_req;
  sispd_cfg_t cfg;
  logic [71:0] exp_q[$];
  int miscompares, n_compared, r;
  logic [7:0] wsub[4] = '{SISPD_SUB_LOCK_WR, SISPD_SUB_FUSE_LO_WR, SISPD_SUB_FUSE_HI_WR,
    SISPD_SUB_FUSE_EX_WR};
  sispd_mem_op_t wop[4] = '{SISPD_M_LOCK, SISPD_M_FUSE_LO, SISPD_M_FUSE_HI, SISPD_M_FUSE_EX};
  logic [15:0] rsel[4] = '{{SISPD_OP_CFG_B, SISPD_ZERO}, {SISPD_OP_CFG_A, SISPD_ZERO},
    {SISPD_OP_CFG_B, SISPD_SUB_CFG_ALT}, {SISPD_OP_CFG_A, SISPD_SUB_CFG_ALT}};
  logic [7:0] rop[3] = '{SISPD_OP_RD_HI, SISPD_OP_RD_LO, SISPD_OP_EE_READ};

  sispd_decoder #(.SIG_BYTE0(SIGS[7:0]), .SIG_BYTE1(SIGS[15:8]), .SIG_BYTE2(SIGS[23:16]),
    .CAL_BYTE(CAL)) dut_u (.clk(clk), .rst(rst), .sck(sck), .mosi(mosi),
    .reset_pin_n(reset_pin_n), .miso(miso), .miso_oe(miso_oe), .mem_req(mem_req),
    .mem_busy(mem_busy), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data),
    .page_wr_data(page_wr_data), .page_wr_addr(page_wr_addr), .page_wr_hi_en(page_wr_hi_en),
    .page_wr_lo_en(page_wr_lo_en), .ee_buf_data(ee_buf_data), .ee_buf_addr(ee_buf_addr),
    .ee_buf_en(ee_buf_en), .cfg(cfg), .prog_enabled(prog_enabled),
    .pending_operation_flag(pending_operation_flag));
  sispd_prog_model prog_u (.sck(sck), .mosi(mosi), .miso(miso), .got(got), .got_tgl(got_tgl));

  task automatic stop_test();
    if (miscompares == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic note(input logic [35:0] m, input logic [35:0] v);
    exp_q.push_back({m, v});
  endtask
  task automatic check(input logic [35:0] act);
    logic [71:0] e;
    n_compared++;
    e = (exp_q.size() == 0) ? {36'hF_FFFF_FFFF, 36'h0} : exp_q.pop_front();
    if (((act ^ e[35:0]) & e[71:36]) !== 36'h0) begin
      miscompares++;
      $display("BAD t=%0t exp=%h act=%h", $time, e[35:0], act);
    end
  endtask
  task automatic run(input logic [31:0] ins, input bit k3, input bit k4);
    #1;
    prog_u.xfer(ins, k3, k4);
    repeat (12) @(posedge clk);
  endtask
  task automatic rd(input logic [31:0] ins, input logic [7:0] m, input logic [7:0] v);
    note({4'hF, 24'h0, m}, {4'hF, 24'h0, v});
    run(ins, 1'b0, 1'b1);
  endtask
  task automatic enable();
    note(36'hF_0000_00FF, {28'hF00_0000, SISPD_SUB_ENABLE});
    run({SISPD_OP_PROG, SISPD_SUB_ENABLE, 16'h0000}, 1'b1, 1'b0);
  endtask

  // Every output event and every returned byte takes the oldest expectation.
  always @(posedge clk) begin
    if (mem_req.valid) check({mem_req.op, mem_req.addr, mem_req.data});
    if (page_wr_lo_en) check({4'hB, 8'h0, page_wr_addr, page_wr_data});
    if (page_wr_hi_en) check({4'hC, 8'h0, page_wr_addr, page_wr_data});
    if (ee_buf_en) check({4'hE, 22'h0, ee_buf_addr, ee_buf_data});
    if (got_tgl !== got_seen) begin
      got_seen <= got_tgl;
      check({4'hF, 24'h0, got});
    end
  end
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #300us;
    miscompares++;
    stop_test();
  end
  initial begin
    rst = 1'b1;
    reset_pin_n = 1'b1;
    mem_busy = 1'b0;
    mem_rd_valid = 1'b0;
    mem_rd_data = 8'h00;
    miscompares = 0;
    n_compared = 0;
    r = $urandom(83);
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    repeat (2) @(posedge clk);
    #1 reset_pin_n = 1'b0;
    repeat (4) @(posedge clk);
    run({SISPD_OP_PROG, SISPD_SUB_FUSE_LO_WR, 16'h0000}, 1'b0, 1'b0);
    enable();
    rd({SISPD_OP_CFG_A, 24'h0}, 8'hFF, SISPD_CFG_RESET);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom()) | 8'hC0;
      note(36'hF_0000_00FF, {wop[i], 24'h0, d});
      run({SISPD_OP_PROG, wsub[i], 8'h00, d}, 1'b0, 1'b0);
      rd({rsel[i], 16'h0000}, 8'hFF, d);
    end
    note(36'hF_0000_0000, {SISPD_M_ERASE, 32'h0});
    run({SISPD_OP_PROG, SISPD_SUB_ERASE, 16'h0000}, 1'b0, 1'b0);
    rd({SISPD_OP_CFG_B, 24'h0}, 8'hFF, SISPD_CFG_RESET);
    for (int b = 1; b >= 0; b--) begin
      @(posedge clk);
      #1 mem_busy = b[0];
      rd({SISPD_OP_POLL, 24'h0}, 8'h01, {7'h0, b[0]});
    end
    ext = 8'($urandom());
    run({SISPD_OP_EXT_ADDR, 8'h00, ext, 8'h00}, 1'b0, 1'b0);
    for (int p = 0; p < 2; p++) begin
      a = 8'($urandom());
      d = 8'($urandom());
      w = 8'($urandom());
      note(36'hF_00FF_00FF, {4'hB, 8'h0, a, 8'h0, d});
      run({SISPD_OP_LOAD_LO, 8'h00, a, d}, 1'b0, 1'b0);
      note(36'hF_00FF_FF00, {4'hC, 8'h0, a, w, 8'h0});
      run({SISPD_OP_LOAD_HI, 8'h00, a, w}, 1'b0, 1'b0);
      note(36'hF_FFFF_FF00, {SISPD_M_FLASH_PAGE, ext, w, a, 8'h0});
      run({SISPD_OP_WR_PAGE, w, a, 8'h00}, 1'b0, 1'b0);
    end
    for (int i = 3; i >= 0; i--) begin
      d = 8'($urandom());
      note(36'hF_0000_03FF, {4'hE, 22'h0, 2'(i), d});
      run({SISPD_OP_EE_LOAD, 8'h00, 6'h0, 2'(i), d}, 1'b0, 1'b0);
    end
    note(36'hF_FFFF_FF00, {SISPD_M_EE_PAGE, 16'h0001, 8'h24, 8'h0});
    run({SISPD_OP_EE_PAGE, 8'h01, 8'h24, 8'h00}, 1'b0, 1'b0);
    d = 8'($urandom());
    note(36'hF_FFFF_FFFF, {SISPD_M_EE_BYTE, 16'h0002, 8'h5B, d});
    run({SISPD_OP_EE_WRITE, 8'h02, 8'h5B, d}, 1'b0, 1'b0);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      #1 mem_rd_valid = 1'b1;
      mem_rd_data = 8'($urandom());
      rd({rop[i], 8'h01, 8'($urandom()), 8'h00}, 8'hFF, mem_rd_data);
    end
    for (int i = 0; i < 3; i++) begin
      rd({SISPD_OP_SIG, 8'h00, 8'(i), 8'h00}, 8'hFF, SIGS[8*i +: 8]);
    end
    rd({SISPD_OP_CAL, 24'h0}, 8'hFF, CAL);
    run({8'h77, 8'h12, 8'h34, 8'h56}, 1'b0, 1'b0);
    @(posedge clk);
    #1 reset_pin_n = 1'b1;
    repeat (8) @(posedge clk);
    #1 reset_pin_n = 1'b0;
    repeat (4) @(posedge clk);
    enable();
    n_compared++;
    if (exp_q.size() != 0) begin
      miscompares++;
      $display("BAD t=%0t exp=%h act=%h", $time, 0, exp_q.size());
    end
    stop_test();
  end
endmodule // sispd_decoder_tb
